// ==== core/poc_pkg.sv ====
// Shared constants, register map and state encoding of the optic control core.
// Assumes one 50 MHz system clock and a synchronous active-high reset.
//
// How it works
// - Presence pin is held grounded while installed.
// - Definition lines carry serial clock and data.
// - Bandwidth select low gives reduced, high gives full.
// - Signal-lost output high when optical power low.
// - Shut-off rise turns laser off within 10 us.
// - Shut-off fall turns laser on within 1 ms.
// - Fault may show at power-up until safety confirms.
// - Fault clears within 300 ms of supply valid.
// - With shut-off at power-up, initialise after release.
// - Fault output rises within 100 us of fault.
// - Signal-lost follows loss state within 100 us.
// - Bandwidth follows select edge within 10 us.
// - Hot insertion runs the normal power-up initialisation.
// - Safety circuitry present means fault output implemented.
// - Without fault function, output stays low always.
// - Laser off when shut-off high, on only low.
// - Fault output high means fault, low means normal.
// - Safety fault latches until shut-off pulse and gone.
package poc_pkg;

  localparam int CLK_MHZ    = 50;
  localparam int T_RESET_NS = 10_000;
  localparam int T_INIT_MS  = 300;
  localparam int TMR_W      = 24;

  function automatic int poc_ns_to_cyc_up(input int ns);
    poc_ns_to_cyc_up = (ns * CLK_MHZ + 999) / 1000;
  endfunction : poc_ns_to_cyc_up

  function automatic int poc_ms_to_cyc_dn(input int ms);
    poc_ms_to_cyc_dn = ms * 1000 * CLK_MHZ;
  endfunction : poc_ms_to_cyc_dn

  // The hold check is two cycles shorter than the minimum so a host that holds exactly
  // the minimum still clears the latch despite the timer's load cycle and its registered done.
  localparam int RESET_CYC = poc_ns_to_cyc_up(T_RESET_NS) - 2;
  localparam int INIT_CYC  = poc_ms_to_cyc_dn(T_INIT_MS);

  localparam int          ADDR_W     = 4;
  localparam int          DATA_W     = 32;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;

  localparam int          CTRL_W          = 2;
  localparam int          CTRL_FAULT_IMPL = 0;
  localparam int          CTRL_FORCE_OFF  = 1;
  localparam logic [1:0]  CTRL_RST        = 2'h1;

  localparam int ST_STATE    = 0;
  localparam int ST_LASER_EN = 2;
  localparam int ST_RX_LOST  = 3;
  localparam int ST_BW_FULL  = 4;
  localparam int ST_SUPPLY   = 5;
  localparam int ST_FLT_PIN  = 6;
  localparam int ST_LOS_PIN  = 7;
  localparam int ST_PRES_PIN = 8;
  localparam int ST_HOLD_MET = 9;
  localparam int ST_W        = 10;

  typedef enum logic [1:0] {
    POC_OFF   = 2'b00,
    POC_INIT  = 2'b01,
    POC_RUN   = 2'b11,
    POC_FAULT = 2'b10
  } poc_state_t;

endpackage : poc_pkg

// ==== core/poc_tmr_if.sv ====
// Start/load/done bundle between the control core and a countdown timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface poc_tmr_if #(parameter int W = 24);
  logic         start;
  logic [W-1:0] load;
  logic         busy;
  logic         done;

  modport ctl (output start, output load, input busy, input done);
  modport tmr (input start, input load, output busy, output done);
endinterface : poc_tmr_if

// ==== core/poc_sync.sv ====
// Two-stage level synchroniser with a per-bit reset value.
// Assumes inputs may change at any time relative to clk_sys_i.
`timescale 1ns/1ps
module poc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys_i, // System clock.
  input  wire logic         srst_i,    // Synchronous reset.
  input  wire logic         ce_i,      // Clock enable.
  input  wire logic [W-1:0] d_i,       // Raw levels.
  output logic      [W-1:0] q_o        // Synchronised levels.
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else if (ce_i) begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule : poc_sync

// ==== core/poc_timer.sv ====
// Countdown timer: start loads the count, done pulses for one cycle when it runs out.
// Assumes start is only raised while the caller wants a fresh interval.
`timescale 1ns/1ps
module poc_timer #(
  parameter int W = 24
) (
  input  wire logic clk_sys_i, // System clock.
  input  wire logic srst_i,    // Synchronous reset.
  input  wire logic ce_i,      // Clock enable.
  poc_tmr_if.tmr    t          // Control bundle.
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         done_ff;
  logic         nxt_done;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (t.start) begin
      nxt_cnt = t.load;
    end else if (cnt_ff != '0) begin
      nxt_cnt  = cnt_ff - W'(1);
      nxt_done = (cnt_ff == W'(1));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (ce_i) begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign t.busy = (cnt_ff != '0);
  assign t.done = done_ff;
endmodule : poc_timer

// ==== core/poc_optic_ctrl.sv ====
// Control and status core of a pluggable optical transceiver, module side.
// Assumes the safety and supply detectors are synchronous to clk_sys_i (the receive-power flag goes through poc_sync),
// and that the board resolves each open-drain pin from its output and enable.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module poc_optic_ctrl
  import poc_pkg::*;
#(
  parameter logic [TMR_W-1:0] INIT_CYC_P  = TMR_W'(INIT_CYC),
  parameter logic [TMR_W-1:0] RESET_CYC_P = TMR_W'(RESET_CYC)
) (
  input  wire logic              clk_sys_i,      // 50 MHz system clock.
  input  wire logic              srst_i,         // Synchronous reset, active high.
  input  wire logic              ce_i,           // Clock enable, freezes all state.
  input  wire logic              tx_shutoff_i,   // Host shut-off line, high disables.
  input  wire logic              bw_select_i,    // Host bandwidth select line.
  input  wire logic              supply_ok_i,    // Transmitter supply at minimum.
  input  wire logic              laser_fault_i,  // Safety circuitry sees a fault.
  input  wire logic              laser_ok_i,     // Safety circuitry confirms normal.
  input  wire logic              rx_power_low_i, // Received power below sensitivity.
  input  wire logic              fault_pin_i,    // Fault line level read back.
  output logic                   fault_o,        // Fault line drive value, always 0.
  output logic                   fault_oe_n_o,   // Low pulls fault line low.
  input  wire logic              los_pin_i,      // Signal-lost line level read back.
  output logic                   los_o,          // Signal-lost drive value, always 0.
  output logic                   los_oe_n_o,     // Low pulls signal-lost line low.
  input  wire logic              present_pin_i,  // Presence line level read back.
  output logic                   present_o,      // Presence drive value, always 0.
  output logic                   present_oe_n_o, // Low grounds presence line.
  input  wire logic              scl_i,          // Serial ID clock from host.
  input  wire logic              sda_i,          // Serial ID data line level.
  output logic                   sda_o,          // Serial ID data drive, always 0.
  output logic                   sda_oe_n_o,     // Low pulls serial ID data low.
  output logic                   id_scl_o,       // Serial clock to ID memory.
  output logic                   id_sda_o,       // Serial data to ID memory.
  input  wire logic              id_sda_low_i,   // ID memory pulls data low.
  output logic                   laser_en_o,     // Laser driver enable.
  output logic                   bw_full_o,      // Receiver full bandwidth.
  input  wire logic [ADDR_W-1:0] addr_i,         // Register byte address.
  input  wire logic [DATA_W-1:0] wr_data_i,      // Register write data.
  input  wire logic              wr_i,           // Write strobe.
  input  wire logic              rd_i,           // Read strobe.
  output logic      [DATA_W-1:0] rd_data_o       // Read data, cycle after strobe.
);
  logic       shutoff_s;
  logic       bw_s;
  logic       lost_s;
  logic       scl_s;
  logic       sda_s;

  poc_sync #(.W(5), .RST_VAL(5'h13)) u_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .d_i       ({tx_shutoff_i, bw_select_i, rx_power_low_i, scl_i, sda_i}),
    .q_o       ({shutoff_s, bw_s, lost_s, scl_s, sda_s})
  );

  poc_tmr_if #(.W(TMR_W)) init_t ();
  poc_tmr_if #(.W(TMR_W)) hold_t ();

  poc_timer #(.W(TMR_W)) u_init_tmr (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .t         (init_t)
  );

  poc_timer #(.W(TMR_W)) u_hold_tmr (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .t         (hold_t)
  );

  poc_state_t        state_ff;
  poc_state_t        nxt_state;
  logic              shutoff_d_ff;
  logic              hold_met_ff;
  logic              nxt_hold_met;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl;
  logic              laser_en_ff;
  logic              nxt_laser_en;
  logic              fault_rel_ff;
  logic              nxt_fault_rel;
  logic              los_rel_ff;
  logic              bw_full_ff;
  logic              scl_ff;
  logic              sda_ff;
  logic              sda_rel_ff;
  logic              pin_low_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] nxt_rd_data;
  logic [ST_W-1:0]   status;
  logic              shut_rise;
  logic              shut_fall;

  assign shut_rise = shutoff_s & ~shutoff_d_ff;
  assign shut_fall = ~shutoff_s & shutoff_d_ff;

  assign init_t.load  = INIT_CYC_P;
  assign hold_t.load  = RESET_CYC_P;
  assign hold_t.start = shut_rise;

  assign status = {hold_met_ff, present_pin_i, los_pin_i, fault_pin_i, supply_ok_i,
                   bw_full_ff, lost_s, laser_en_ff, state_ff};

  // Transmitter safety state and latched fault.
  always_comb begin
    nxt_state    = state_ff;
    init_t.start = 1'b0;
    nxt_hold_met = hold_met_ff;
    if (shut_rise) begin
      nxt_hold_met = 1'b0;
    end else if (hold_t.done && shutoff_s) begin
      nxt_hold_met = 1'b1;
    end
    if (!supply_ok_i) begin
      nxt_state = POC_OFF;
    end else begin
      unique case (state_ff)
        POC_OFF: begin
          if (!shutoff_s) begin
            nxt_state    = POC_INIT;
            init_t.start = 1'b1;
          end
        end
        POC_INIT: begin
          if (laser_fault_i) begin
            nxt_state = POC_FAULT;
          end else if (shutoff_s) begin
            nxt_state = POC_OFF;
          end else if (laser_ok_i) begin
            nxt_state = POC_RUN;
          end else if (init_t.done) begin
            nxt_state = POC_FAULT;
          end
        end
        POC_RUN: begin
          if (laser_fault_i) begin
            nxt_state = POC_FAULT;
          end
        end
        POC_FAULT: begin
          if (shut_fall && hold_met_ff) begin
            nxt_state    = POC_INIT;
            init_t.start = 1'b1;
          end
        end
      endcase
    end
    nxt_laser_en = ((nxt_state == POC_INIT) || (nxt_state == POC_RUN)) && !shutoff_s
                   && !ctrl_ff[CTRL_FORCE_OFF];
    // Only a core with safety circuitry may release the line; otherwise it stays low.
    nxt_fault_rel = ctrl_ff[CTRL_FAULT_IMPL] && (nxt_state != POC_RUN);
  end

  // Register port.
  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_rd_data = '0;
    if (wr_i && (addr_i == REG_CTRL)) begin
      nxt_ctrl = wr_data_i[CTRL_W-1:0];
    end
    if (rd_i) begin
      if (addr_i == REG_CTRL) begin
        nxt_rd_data = DATA_W'(ctrl_ff);
      end else if (addr_i == REG_STATUS) begin
        nxt_rd_data = DATA_W'(status);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_ff     <= POC_OFF;
      shutoff_d_ff <= 1'b1;
      hold_met_ff  <= 1'b0;
      ctrl_ff      <= CTRL_RST;
      laser_en_ff  <= 1'b0;
      fault_rel_ff <= 1'b1;
      los_rel_ff   <= 1'b1;
      bw_full_ff   <= 1'b0;
      scl_ff       <= 1'b1;
      sda_ff       <= 1'b1;
      sda_rel_ff   <= 1'b1;
      pin_low_ff   <= 1'b0;
      rd_data_ff   <= '0;
    end else if (ce_i) begin
      state_ff     <= nxt_state;
      shutoff_d_ff <= shutoff_s;
      hold_met_ff  <= nxt_hold_met;
      ctrl_ff      <= nxt_ctrl;
      laser_en_ff  <= nxt_laser_en;
      fault_rel_ff <= nxt_fault_rel;
      los_rel_ff   <= lost_s;
      bw_full_ff   <= bw_s;
      scl_ff       <= scl_s;
      sda_ff       <= sda_s;
      sda_rel_ff   <= ~id_sda_low_i;
      pin_low_ff   <= 1'b0;
      rd_data_ff   <= nxt_rd_data;
    end
  end

  assign fault_o        = pin_low_ff;
  assign fault_oe_n_o   = fault_rel_ff;
  assign los_o          = pin_low_ff;
  assign los_oe_n_o     = los_rel_ff;
  assign present_o      = pin_low_ff;
  assign present_oe_n_o = pin_low_ff;
  assign sda_o          = pin_low_ff;
  assign sda_oe_n_o     = sda_rel_ff;
  assign id_scl_o       = scl_ff;
  assign id_sda_o       = sda_ff;
  assign laser_en_o     = laser_en_ff;
  assign bw_full_o      = bw_full_ff;
  assign rd_data_o      = rd_data_ff;

  // Delays are relative to raw pins: two synchroniser stages plus the output flop, or the output flop alone for laser_fault_i.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i || !ce_i);

  chk_shutoff_laser_off: assert property (
    tx_shutoff_i [*3] |=> !laser_en_o)
    else $error("Laser still enabled after shut-off.");

  chk_release_laser_on: assert property (
    (!tx_shutoff_i && state_ff == POC_RUN && supply_ok_i && !laser_fault_i
     && !ctrl_ff[CTRL_FORCE_OFF]) [*3] |=> laser_en_o)
    else $error("Laser not enabled after release.");

  chk_fault_raise: assert property (
    ctrl_ff[CTRL_FAULT_IMPL] && supply_ok_i && laser_fault_i
    && state_ff != POC_OFF |-> ##[1:2] fault_oe_n_o)
    else $error("Fault line not released after fault.");

  chk_fault_latched: assert property (
    state_ff == POC_FAULT && !hold_met_ff && supply_ok_i |=> state_ff == POC_FAULT)
    else $error("Fault latch left without reset pulse.");

  chk_no_impl_low: assert property (
    !ctrl_ff[CTRL_FAULT_IMPL] [*2] |-> !fault_oe_n_o)
    else $error("Fault line released without fault function.");

  chk_los_follow: assert property (
    rx_power_low_i [*3] |=> los_oe_n_o)
    else $error("Signal-lost not raised.");

  chk_los_clear: assert property (
    !rx_power_low_i [*3] |=> !los_oe_n_o)
    else $error("Signal-lost not cleared.");

  chk_bw_follow: assert property (
    bw_select_i [*3] |=> bw_full_o)
    else $error("Bandwidth not following select.");

  chk_bw_reduced: assert property (
    !bw_select_i [*3] |=> !bw_full_o)
    else $error("Bandwidth not reduced after select low.");

  chk_present_gnd: assert property (
    $past(ce_i) |-> !present_oe_n_o && !present_o)
    else $error("Presence line not grounded.");

  chk_init_clear: assert property (
    state_ff == POC_INIT && laser_ok_i && !laser_fault_i && supply_ok_i && !shutoff_s
    |=> state_ff == POC_RUN ##0 !fault_oe_n_o)
    else $error("Fault line not cleared after initialisation.");

  chk_supply_drop: assert property (
    !supply_ok_i |=> state_ff == POC_OFF)
    else $error("Supply loss did not restart initialisation.");

  cov_run: cover property (state_ff == POC_INIT ##1 state_ff == POC_RUN);
  cov_recover: cover property (state_ff == POC_FAULT ##1 state_ff == POC_INIT);
  cov_timeout: cover property (state_ff == POC_INIT && init_t.done);
  cov_los: cover property ($rose(los_oe_n_o));
endmodule : poc_optic_ctrl

// ==== tb/poc_host_model.sv ====
// Host board model: pull-ups on the open-drain lines and the shut-off driver.
// Assumes the core gives each open-drain line as a drive value plus active-low enable.
`timescale 1ns/1ps
module poc_host_model #(
  parameter int HOLD_CYC = 24,
  parameter int WIN_CYC  = 210
) (
  input  wire logic clk_sys_i,      // System clock.
  input  wire logic srst_i,         // Synchronous reset.
  input  wire logic shut_req_i,     // Host wants the transmitter off.
  input  wire logic rush_i,         // Skip the minimum hold on purpose.
  input  wire logic flt_drv_i,      // Fault line drive value.
  input  wire logic flt_oe_n_i,     // Fault line enable, low drives.
  input  wire logic los_drv_i,      // Signal-lost drive value.
  input  wire logic los_oe_n_i,     // Signal-lost enable, low drives.
  input  wire logic pres_drv_i,     // Presence drive value.
  input  wire logic pres_oe_n_i,    // Presence enable, low drives.
  input  wire logic sda_drv_i,      // Serial data drive value.
  input  wire logic sda_oe_n_i,     // Serial data enable, low drives.
  input  wire logic host_sda_low_i, // Host pulls serial data low.
  output logic      tx_shutoff_o,   // Shut-off line to the module.
  output logic      fault_pin_o,    // Resolved fault line.
  output logic      los_pin_o,      // Resolved signal-lost line.
  output logic      present_pin_o,  // Resolved presence line.
  output logic      sda_pin_o,      // Resolved serial data line.
  output logic      fault_seen_o    // Fault line high past the init window.
);
  logic [7:0] hold_ff;
  logic [8:0] high_ff;

  // Every line has a pull-up, so a released line reads high, never the last value.
  assign fault_pin_o   = flt_oe_n_i ? 1'b1 : flt_drv_i;
  assign los_pin_o     = los_oe_n_i ? 1'b1 : los_drv_i;
  assign present_pin_o = pres_oe_n_i ? 1'b1 : pres_drv_i;
  assign sda_pin_o     = (sda_oe_n_i | sda_drv_i) & ~host_sda_low_i;
  assign fault_seen_o  = (high_ff > 9'(WIN_CYC));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hold_ff      <= 8'h00;
      high_ff      <= 9'h000;
      tx_shutoff_o <= 1'b0;
    end else begin
      // A request is stretched to the minimum hold unless a scenario rushes it.
      if (shut_req_i && !rush_i) begin
        hold_ff <= 8'(HOLD_CYC);
      end else if (hold_ff != 8'h00) begin
        hold_ff <= hold_ff - 8'h01;
      end
      tx_shutoff_o <= shut_req_i | (hold_ff != 8'h00);
      if (!fault_pin_o) begin
        high_ff <= 9'h000;
      end else if (!fault_seen_o) begin
        high_ff <= high_ff + 9'h001;
      end
    end
  end
endmodule : poc_host_model

// ==== tb/poc_optic_ctrl_tb.sv ====
// Self-checking bench of the optic control core beside the host board model.
// Assumes a 50 MHz clock and shortened init and hold counts.
`timescale 1ns/1ps
module poc_optic_ctrl_tb
  import poc_pkg::*;
;
  localparam logic [TMR_W-1:0] INIT_P = 24'h0000C8;
  localparam logic [TMR_W-1:0] HOLD_P = 24'h000014;
  logic clk_sys_i, srst_i, ce_i, shut_req, rush, bw_select_i, supply_ok_i, seen;
  logic laser_fault_i, laser_ok_i, rx_power_low_i, scl_i, host_sda_low, id_sda_low_i;
  logic wr_i, rd_i, tx_shutoff_i, fault_pin_i, los_pin_i, present_pin_i, sda_i;
  logic fault_o, fault_oe_n_o, los_o, los_oe_n_o, present_o, present_oe_n_o;
  logic sda_o, sda_oe_n_o, id_scl_o, id_sda_o, laser_en_o, bw_full_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wr_data_i, rd_data_o, rdv;
  int               miscompares, compares;

  poc_optic_ctrl #(.INIT_CYC_P(INIT_P), .RESET_CYC_P(HOLD_P)) u_poc_optic_ctrl (
    .clk_sys_i, .srst_i, .ce_i, .tx_shutoff_i, .bw_select_i, .supply_ok_i, .laser_fault_i,
    .laser_ok_i, .rx_power_low_i, .fault_pin_i, .fault_o, .fault_oe_n_o, .los_pin_i, .los_o,
    .los_oe_n_o, .present_pin_i, .present_o, .present_oe_n_o, .scl_i, .sda_i, .sda_o,
    .sda_oe_n_o, .id_scl_o, .id_sda_o, .id_sda_low_i, .laser_en_o, .bw_full_o, .addr_i,
    .wr_data_i, .wr_i, .rd_i, .rd_data_o);

  poc_host_model u_poc_host_model (
    .clk_sys_i, .srst_i, .shut_req_i(shut_req), .rush_i(rush), .flt_drv_i(fault_o),
    .flt_oe_n_i(fault_oe_n_o), .los_drv_i(los_o), .los_oe_n_i(los_oe_n_o),
    .pres_drv_i(present_o), .pres_oe_n_i(present_oe_n_o), .sda_drv_i(sda_o),
    .sda_oe_n_i(sda_oe_n_o), .host_sda_low_i(host_sda_low), .tx_shutoff_o(tx_shutoff_i),
    .fault_pin_o(fault_pin_i), .los_pin_o(los_pin_i), .present_pin_o(present_pin_i),
    .sda_pin_o(sda_i), .fault_seen_o(seen));

  function automatic logic exp_sda(input logic host_low, input logic mem_low);
    return ~(host_low | mem_low);
  endfunction : exp_sda

  function automatic logic exp_fault(input logic impl, input logic flt);
    return impl & flt;
  endfunction : exp_fault

  task automatic chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  // Sampling one time unit after the edge keeps checks clear of the edge's own updates.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : reg_rd

  task automatic chk_state(input poc_state_t s);
    logic [DATA_W-1:0] d;
    reg_rd(REG_STATUS, d);
    chk_word("state", 32'(s), d & 32'h00000003);
  endtask : chk_state

  task automatic host_reset(input logic quick, input int n);
    @(posedge clk_sys_i);
    rush     <= quick;
    shut_req <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    shut_req <= 1'b0;
    cyc(40);
  endtask : host_reset

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    repeat (30000) @(posedge clk_sys_i);
    miscompares++;
    results();
  end

  initial begin
    {srst_i, ce_i, scl_i} = 3'h7;
    {shut_req, rush, bw_select_i, supply_ok_i, laser_fault_i, laser_ok_i} = 6'h00;
    {rx_power_low_i, host_sda_low, id_sda_low_i, wr_i, rd_i} = 5'h00;
    addr_i = 4'h0;
    wr_data_i = 32'h00000000;
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    void'($urandom(32'hAB8C));
    cyc(2);
    chk_bit("present_oe_n", 1'b0, present_oe_n_o);
    chk_bit("present_line", 1'b0, present_pin_i);
    chk_bit("fault_line", 1'b1, fault_pin_i);
    chk_bit("laser_en", 1'b0, laser_en_o);
    chk_bit("id_scl_idle", 1'b1, id_scl_o);
    reg_wr(4'h8, 32'hFFFFFFFF);
    reg_rd(4'h8, rdv);
    chk_word("unmapped", 32'h00000000, rdv);
    reg_rd(REG_CTRL, rdv);
    chk_word("ctrl", {30'h0, CTRL_RST}, rdv);
    // Power-up with the transmitter enabled.
    @(posedge clk_sys_i);
    supply_ok_i <= 1'b1;
    cyc(3);
    chk_bit("fault_line", 1'b1, fault_pin_i);
    chk_state(POC_INIT);
    @(posedge clk_sys_i);
    laser_ok_i <= 1'b1;
    cyc(3);
    chk_bit("fault_line", exp_fault(1'b1, 1'b0), fault_pin_i);
    chk_bit("laser_en", 1'b1, laser_en_o);
    chk_state(POC_RUN);
    // Random line traffic, serial clock kept at or below its ceiling.
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys_i);
      bw_select_i    <= 1'($urandom());
      rx_power_low_i <= 1'($urandom());
      scl_i          <= 1'($urandom());
      host_sda_low   <= 1'($urandom());
      id_sda_low_i   <= 1'($urandom());
      cyc(256);
      chk_bit("bw_full", bw_select_i, bw_full_o);
      chk_bit("los_line", rx_power_low_i, los_pin_i);
      chk_bit("id_scl", scl_i, id_scl_o);
      chk_bit("id_sda", exp_sda(host_sda_low, id_sda_low_i), id_sda_o);
    end
    // Shut-off in normal operation, then the register override.
    host_reset(1'b0, 1);
    chk_bit("laser_en", 1'b1, laser_en_o);
    @(posedge clk_sys_i);
    shut_req <= 1'b1;
    @(posedge clk_sys_i);
    shut_req <= 1'b0;
    cyc(5);
    chk_bit("laser_en", 1'b0, laser_en_o);
    chk_state(POC_RUN);
    // The host stretches the pulse, so wait until it ends and only the override can stop the laser.
    cyc(30);
    chk_bit("laser_en", 1'b1, laser_en_o);
    reg_wr(REG_CTRL, 32'h00000003);
    cyc(3);
    chk_bit("forced_off", 1'b0, laser_en_o);
    reg_wr(REG_CTRL, 32'h00000001);
    cyc(3);
    chk_bit("laser_en", 1'b1, laser_en_o);
    chk_bit("host_fault_seen", 1'b0, seen);
    // Transient fault, a rushed reset, then a proper one.
    @(posedge clk_sys_i);
    laser_fault_i <= 1'b1;
    cyc(2);
    chk_bit("fault_line", 1'b1, fault_pin_i);
    chk_bit("laser_en", 1'b0, laser_en_o);
    @(posedge clk_sys_i);
    laser_fault_i <= 1'b0;
    cyc(5);
    chk_bit("fault_line", 1'b1, fault_pin_i);
    host_reset(1'b1, 3);
    chk_state(POC_FAULT);
    host_reset(1'b0, 1);
    chk_bit("fault_line", 1'b0, fault_pin_i);
    chk_bit("laser_en", 1'b1, laser_en_o);
    // A fault that persists through the reset latches again.
    @(posedge clk_sys_i);
    laser_fault_i <= 1'b1;
    host_reset(1'b0, 1);
    chk_bit("fault_line", 1'b1, fault_pin_i);
    laser_fault_i <= 1'b0;
    // Safety circuitry never confirms: the init window runs out.
    laser_ok_i <= 1'b0;
    host_reset(1'b0, 1);
    cyc(240);
    chk_state(POC_FAULT);
    chk_bit("host_fault_seen", 1'b1, seen);
    laser_ok_i <= 1'b1;
    host_reset(1'b0, 1);
    chk_state(POC_RUN);
    // Power-up with shut-off held.
    @(posedge clk_sys_i);
    supply_ok_i <= 1'b0;
    shut_req    <= 1'b1;
    cyc(5);
    supply_ok_i <= 1'b1;
    cyc(10);
    chk_state(POC_OFF);
    chk_bit("laser_en", 1'b0, laser_en_o);
    shut_req <= 1'b0;
    cyc(40);
    chk_state(POC_RUN);
    chk_bit("fault_line", 1'b0, fault_pin_i);
    // Frozen clock enable holds the bandwidth output.
    @(posedge clk_sys_i);
    ce_i        <= 1'b0;
    bw_select_i <= ~bw_select_i;
    cyc(6);
    chk_bit("bw_frozen", ~bw_select_i, bw_full_o);
    ce_i <= 1'b1;
    cyc(6);
    chk_bit("bw_full", bw_select_i, bw_full_o);
    // Fault function switched off keeps the line low.
    reg_wr(REG_CTRL, 32'h00000000);
    reg_rd(REG_CTRL, rdv);
    chk_word("ctrl", 32'h00000000, rdv);
    laser_fault_i <= 1'b1;
    cyc(3);
    chk_bit("fault_line", exp_fault(1'b0, 1'b1), fault_pin_i);
    laser_fault_i <= 1'b0;
    reg_wr(REG_CTRL, 32'h00000001);
    cyc(3);
    chk_bit("fault_line", exp_fault(1'b1, 1'b1), fault_pin_i);
    results();
  end
endmodule : poc_optic_ctrl_tb
